/* hdl/pss_pkg.sv */
package pss_pkg;
  localparam int LOC_COUNT = 40;
  localparam int LOC_W = 6;
  localparam int SET_W = 16;
  localparam int DWELL_W = 16;
  // Dwell unit is 10 ms, default one unit
  localparam int DWELL_UNIT_NS = 10000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_CYCLES = DWELL_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [DWELL_W-1:0] DWELL_DEFAULT = 16'h0001;
  localparam logic [DWELL_W-1:0] DWELL_MIN = 16'h0001;
  localparam logic [LOC_W-1:0] LOC_END = 6'h00;
  localparam logic [LOC_W-1:0] LOC_FIRST = 6'h01;
  localparam logic [SET_W-1:0] SET_DEFAULT = 16'h0000;

  // Contents of one program location
  typedef struct packed {
    logic [SET_W-1:0] vset;
    logic [SET_W-1:0] iset;
    logic [SET_W-1:0] ovset;
    logic [SET_W-1:0] ocset;
    logic [DWELL_W-1:0] dwell_time_value;
    logic [LOC_W-1:0] next_loc;
  } pss_loc_t;

  // Setpoints driven to the output stage
  typedef struct packed {
    logic [SET_W-1:0] vset;
    logic [SET_W-1:0] iset;
    logic [SET_W-1:0] ovset;
    logic [SET_W-1:0] ocset;
  } pss_set_t;

  // Keypad commands, one-cycle pulses
  typedef struct packed {
    logic run;
    logic step;
    logic enter;
    logic clear;
    logic reset;
    logic out_toggle;
  } pss_key_t;

  // Status for the display
  typedef struct packed {
    logic local_mode;
    logic step_mode;
    logic running;
    logic output_on;
    logic voltage_regulation_flag;
    logic current_regulation_flag;
    logic [LOC_W-1:0] executed_location;
    logic [LOC_W-1:0] pending_location;
    logic [SET_W-1:0] meas_v;
    logic [SET_W-1:0] meas_i;
  } pss_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN_ENTRY = 3'b001,
    ST_RUN = 3'b011,
    ST_RUN_LAST = 3'b010,
    ST_STEP_ENTRY = 3'b110,
    ST_STEP = 3'b111,
    ST_HALT_OFF = 3'b101
  } pss_state_t;
endpackage : pss_pkg

/* hdl/pss_dwell_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// Counts dwell in 10 ms units; done pulses on expiry
module pss_dwell_timer
  import pss_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic abort,
  input wire logic [DWELL_W-1:0] dwell,
  output logic done
);
  logic [31:0] tick_cnt;
  logic [DWELL_W-1:0] unit_cnt;
  logic busy;
  logic [31:0] next_tick_cnt;
  logic [DWELL_W-1:0] next_unit_cnt;
  logic next_busy;
  logic next_done;

  // Prescaler and unit counter
  always_comb begin
    next_tick_cnt = tick_cnt;
    next_unit_cnt = unit_cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (abort) begin
      next_busy = 1'b0;
    end else if (start) begin
      next_busy = 1'b1;
      next_tick_cnt = 32'h0;
      // Zero dwell is clamped to the shortest interval
      next_unit_cnt = (dwell < DWELL_MIN) ? DWELL_MIN : dwell;
    end else if (busy) begin
      if (tick_cnt == 32'(TICK - 1)) begin
        next_tick_cnt = 32'h0;
        if (unit_cnt == DWELL_MIN) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end else begin
          next_unit_cnt = unit_cnt - DWELL_MIN;
        end
      end else begin
        next_tick_cnt = tick_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt <= 32'h0;
      unit_cnt <= DWELL_MIN;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      unit_cnt <= next_unit_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule : pss_dwell_timer
`default_nettype wire

/* hdl/pss_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
// Program step sequencer: 40 locations, run and step modes
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire pss_key_t key,
  input wire logic [LOC_W-1:0] entry_loc,
  input wire logic entry_loc_valid,
  input wire logic wr_en,
  input wire logic [LOC_W-1:0] wr_loc,
  input wire pss_loc_t wr_data,
  input wire logic [SET_W-1:0] meas_v,
  input wire logic [SET_W-1:0] meas_i,
  input wire logic cc_mode,
  output pss_set_t setpoint,
  output logic output_on,
  output pss_stat_t status
);
  pss_loc_t mem [1:LOC_COUNT];
  pss_state_t state;
  pss_state_t next_state;
  logic [LOC_W-1:0] cur_loc;
  logic [LOC_W-1:0] next_cur_loc;
  logic [LOC_W-1:0] start_loc;
  logic [LOC_W-1:0] next_start_loc;
  logic out_en;
  logic next_out_en;
  logic step_mode;
  logic next_step_mode;
  pss_set_t next_setpoint;
  pss_stat_t next_status;
  logic timer_start;
  logic timer_abort;
  logic timer_done;
  logic [SET_W-1:0] mv_s1;
  logic [SET_W-1:0] mv_s2;
  logic [SET_W-1:0] mv_s3;
  logic [SET_W-1:0] mi_s1;
  logic [SET_W-1:0] mi_s2;
  logic [SET_W-1:0] mi_s3;
  logic cc_s1;
  logic cc_s2;

  // Valid locations are 1..40; others count as an end
  function automatic logic loc_ok(input logic [LOC_W-1:0] l);
    loc_ok = (l >= LOC_FIRST) && (l <= LOC_W'(LOC_COUNT));
  endfunction

  function automatic pss_set_t loc_set(input pss_loc_t e);
    loc_set = '{vset: e.vset, iset: e.iset, ovset: e.ovset, ocset: e.ocset};
  endfunction

  // Program storage; every dwell defaults to one unit at reset
  genvar g;
  generate
    for (g = 1; g <= LOC_COUNT; g++) begin : g_mem
      always_ff @(posedge clk) begin
        if (srst) begin
          mem[g] <= '{SET_DEFAULT, SET_DEFAULT, SET_DEFAULT, SET_DEFAULT,
                      DWELL_DEFAULT, LOC_END};
        end else if (wr_en && wr_loc == LOC_W'(g)) begin
          mem[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Measurements and mode flag come from the analog side
  always_ff @(posedge clk) begin
    mv_s1 <= meas_v;
    mv_s2 <= mv_s1;
    mv_s3 <= mv_s2; // Only compared against the second stage
    mi_s1 <= meas_i;
    mi_s2 <= mi_s1;
    mi_s3 <= mi_s2;
    cc_s1 <= cc_mode;
    cc_s2 <= cc_s1;
  end

  // Dwell of the location being loaded, not of the one that just expired
  pss_dwell_timer #(.TICK(TICK)) u_timer (
    .clk(clk),
    .srst(srst),
    .start(timer_start),
    .abort(timer_abort),
    .dwell(mem[loc_ok(next_cur_loc) ? next_cur_loc : LOC_FIRST].dwell_time_value),
    .done(timer_done)
  );

  // Main control; reset key restores the power-on control state but keeps the stored program
  always_comb begin
    next_state = state;
    next_cur_loc = cur_loc;
    next_start_loc = start_loc;
    next_out_en = out_en;
    next_step_mode = step_mode;
    next_setpoint = setpoint;
    timer_start = 1'b0;
    timer_abort = 1'b0;
    if (key.reset) begin
      next_state = ST_IDLE;
      next_cur_loc = LOC_END;
      next_out_en = 1'b0;
      next_step_mode = 1'b0;
      next_setpoint = '{SET_DEFAULT, SET_DEFAULT, SET_DEFAULT, SET_DEFAULT};
      timer_abort = 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (key.out_toggle) begin
            next_out_en = !out_en;
          end else if (key.run || key.step) begin
            next_start_loc = cur_loc;
            next_state = key.run ? ST_RUN_ENTRY : ST_STEP_ENTRY;
          end
        end
        ST_RUN_ENTRY, ST_STEP_ENTRY: begin
          if (entry_loc_valid) begin
            next_start_loc = entry_loc;
          end
          if (key.clear) begin
            next_state = ST_IDLE;
          end else if (key.enter && loc_ok(start_loc)) begin
            next_cur_loc = start_loc;
            next_setpoint = loc_set(mem[start_loc]);
            next_out_en = 1'b1;
            if (state == ST_RUN_ENTRY) begin
              next_state = ST_RUN;
              timer_start = 1'b1;
            end else begin
              next_state = ST_STEP;
              next_step_mode = 1'b1;
            end
          end
        end
        ST_RUN, ST_RUN_LAST: begin
          if (key.out_toggle) begin
            next_out_en = 1'b0;
            next_state = ST_HALT_OFF;
            timer_abort = 1'b1;
          end else if (timer_done) begin
            // Stop on a clear or a pointer outside 1..40, else follow the pointer
            if (state == ST_RUN_LAST || !loc_ok(mem[cur_loc].next_loc)) begin
              next_state = ST_IDLE;
            end else begin
              next_cur_loc = mem[cur_loc].next_loc;
              next_setpoint = loc_set(mem[mem[cur_loc].next_loc]);
              timer_start = 1'b1;
            end
          end else if (key.clear) begin
            next_state = ST_RUN_LAST;
          end
        end
        ST_HALT_OFF: begin
          if (key.out_toggle) begin
            next_out_en = 1'b1;
            next_setpoint = loc_set(mem[cur_loc]);
            next_state = ST_IDLE;
          end
        end
        ST_STEP: begin
          if (key.clear) begin
            next_state = ST_IDLE;
            next_step_mode = 1'b0;
          end else if (key.out_toggle) begin
            next_out_en = !out_en;
          end else if (key.step && loc_ok(mem[cur_loc].next_loc)) begin
            next_cur_loc = mem[cur_loc].next_loc;
            next_setpoint = loc_set(mem[mem[cur_loc].next_loc]);
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Display status follows the executed location
  always_comb begin
    next_status.local_mode = 1'b1;
    next_status.step_mode = next_step_mode;
    next_status.running = (next_state == ST_RUN) || (next_state == ST_RUN_LAST);
    next_status.output_on = next_out_en;
    next_status.voltage_regulation_flag = !cc_s2;
    next_status.current_regulation_flag = cc_s2;
    next_status.executed_location = next_cur_loc;
    next_status.pending_location = loc_ok(next_cur_loc) ? mem[next_cur_loc].next_loc : LOC_END;
    // Readings are words; take one only when two samples agree
    next_status.meas_v = (mv_s3 == mv_s2) ? mv_s2 : status.meas_v;
    next_status.meas_i = (mi_s3 == mi_s2) ? mi_s2 : status.meas_i;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      cur_loc <= LOC_END;
      start_loc <= LOC_FIRST;
      out_en <= 1'b0;
      output_on <= 1'b0;
      step_mode <= 1'b0;
      setpoint <= '{SET_DEFAULT, SET_DEFAULT, SET_DEFAULT, SET_DEFAULT};
      status <= '0;
    end else begin
      state <= next_state;
      cur_loc <= next_cur_loc;
      start_loc <= next_start_loc;
      out_en <= next_out_en;
      output_on <= next_out_en;
      step_mode <= next_step_mode;
      setpoint <= next_setpoint;
      status <= next_status;
    end
  end

  // Step advances exactly to the stored pointer
  property p_step_adv;
    @(posedge clk) disable iff (srst)
    (state == ST_STEP && key.step && !key.clear && !key.out_toggle && !key.reset
     && loc_ok(mem[cur_loc].next_loc))
    |=> (cur_loc == $past(mem[cur_loc].next_loc));
  endproperty
  AST_STEP_ADV: assert property (p_step_adv) else $error("step did not follow pointer");

  AST_RESET_KEY: assert property (@(posedge clk) disable iff (srst)
    key.reset |=> (state == ST_IDLE && !out_en && setpoint.vset == SET_DEFAULT
                   && !status.step_mode)
  ) else $error("reset key did not restore defaults");

  AST_TOGGLE_HALT: assert property (@(posedge clk) disable iff (srst)
    (state == ST_RUN && key.out_toggle && !key.reset)
    |=> (state == ST_HALT_OFF && !out_en && cur_loc == $past(cur_loc))
  ) else $error("toggle did not halt run");

  AST_TOGGLE_BACK: assert property (@(posedge clk) disable iff (srst)
    (state == ST_HALT_OFF && key.out_toggle && !key.reset)
    |=> (output_on && cur_loc == $past(cur_loc) && setpoint == loc_set(mem[cur_loc]))
  ) else $error("second toggle did not restore output");

  AST_STEP_TOGGLE: assert property (@(posedge clk) disable iff (srst)
    (state == ST_STEP && key.out_toggle && !key.clear && !key.reset)
    |=> (state == ST_STEP && out_en != $past(out_en))
  ) else $error("toggle left step mode");

  AST_CLEAR_STEP: assert property (@(posedge clk) disable iff (srst)
    (state == ST_STEP && key.clear && !key.reset)
    |=> (state == ST_IDLE && $stable(setpoint) && !status.step_mode)
  ) else $error("clear in step changed setpoints");

  sequence s_clear_run;
    state == ST_RUN && key.clear && !key.out_toggle && !key.reset && !timer_done;
  endsequence
  AST_CLEAR_RUN: assert property (@(posedge clk) disable iff (srst)
    s_clear_run |=> (state == ST_RUN_LAST && cur_loc == $past(cur_loc))
  ) else $error("clear in run did not finish location");

  AST_END_HOLD: assert property (@(posedge clk) disable iff (srst)
    (state == ST_RUN && timer_done && !key.out_toggle && !key.reset
     && mem[cur_loc].next_loc == LOC_END)
    |=> (state == ST_IDLE && $stable(setpoint) && out_en)
  ) else $error("zero pointer did not end and hold");

  AST_ABANDON: assert property (@(posedge clk) disable iff (srst)
    (state == ST_STEP_ENTRY && key.clear && !key.reset)
    |=> (state == ST_IDLE && $stable(setpoint))
  ) else $error("clear did not abandon step entry");

  // Enter with a usable start location, no clear or reset beside it
  sequence s_confirm;
    key.enter && !key.clear && !key.reset && loc_ok(start_loc);
  endsequence
  AST_ENTER_RUN: assert property (@(posedge clk) disable iff (srst)
    (state == ST_RUN_ENTRY) ##0 s_confirm
    |=> (state == ST_RUN && cur_loc == $past(start_loc) && output_on)
  ) else $error("run did not begin at chosen location");

  AST_ENTER_STEP: assert property (@(posedge clk) disable iff (srst)
    (state == ST_STEP_ENTRY) ##0 s_confirm
    |=> (state == ST_STEP && status.step_mode && cur_loc == $past(start_loc))
  ) else $error("step did not begin at chosen location");

  // Dwell expiry with a live pointer and no toggle or reset key beside it
  sequence s_expiry;
    state == ST_RUN && timer_done && !key.out_toggle && !key.reset
    && loc_ok(mem[cur_loc].next_loc);
  endsequence
  AST_RUN_ADV: assert property (@(posedge clk) disable iff (srst)
    s_expiry |=> (state == ST_RUN && cur_loc == $past(mem[cur_loc].next_loc)
                  && setpoint == loc_set(mem[cur_loc]))
  ) else $error("expiry did not load the next location");

  AST_RESET_RUN: assert property (@(posedge clk) disable iff (srst)
    (status.running && key.reset)
    |=> (!status.running && !output_on && setpoint == {4{SET_DEFAULT}})
  ) else $error("reset did not halt the run");

  // Halted by toggle: output stays off until the second toggle
  AST_HALT_ZERO: assert property (@(posedge clk) disable iff (srst)
    (state == ST_HALT_OFF) |-> (!output_on && !status.running)
  ) else $error("output live while halted");

  AST_STATUS_STEP: assert property (@(posedge clk) disable iff (srst)
    (state == ST_STEP) |-> (status.local_mode && status.step_mode
                            && status.executed_location == cur_loc)
  ) else $error("step status does not show the executed location");
endmodule : pss_sequencer
`default_nettype wire

/* bench/pss_panel_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Front panel stand-in: keypad pulses, typed location, analog readback
module pss_panel_model
  import pss_pkg::*;
(
  input wire logic clk,
  output var pss_key_t key,
  output logic [LOC_W-1:0] entry_loc,
  output logic entry_loc_valid,
  output logic [SET_W-1:0] meas_v,
  output logic [SET_W-1:0] meas_i,
  output logic cc_mode
);
  // Quiet keypad, fixed readings in voltage regulation
  initial begin
    key = '0;
    entry_loc = 6'h00;
    entry_loc_valid = 1'b0;
    meas_v = 16'h1234;
    meas_i = 16'h0567;
    cc_mode = 1'b0;
  end

  // One-cycle key pulse launched just after an edge
  task automatic press(input logic [5:0] k);
    @(posedge clk);
    #1 key = pss_key_t'(k);
    @(posedge clk);
    #1 key = '0;
  endtask

  // Typed digits valid for one edge, then scrambled so stale digits never pass
  task automatic give_loc(input logic [LOC_W-1:0] l);
    @(posedge clk);
    #1 entry_loc = l;
    entry_loc_valid = 1'b1;
    @(posedge clk);
    #1 entry_loc_valid = 1'b0;
    entry_loc = ~l;
  endtask

  // Regulation mode change, launched just after an edge
  task automatic set_cc(input logic v);
    @(posedge clk);
    #1 cc_mode = v;
  endtask

  // Command key, start location, confirm
  task automatic start(input logic [5:0] k, input logic [LOC_W-1:0] l);
    press(k);
    give_loc(l);
    press(6'h08);
  endtask
endmodule // pss_panel_model
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the program step sequencer
module tb_top;
  import pss_pkg::*;
  // Short dwell unit keeps the run brief
  localparam int TK = 4;
  localparam logic [5:0] K_RUN = 6'h20;
  localparam logic [5:0] K_STEP = 6'h10;
  localparam logic [5:0] K_ENT = 6'h08;
  localparam logic [5:0] K_CLR = 6'h04;
  localparam logic [5:0] K_RST = 6'h02;
  localparam logic [5:0] K_TOG = 6'h01;
  logic clk;
  logic srst;
  pss_key_t key;
  logic [LOC_W-1:0] entry_loc;
  logic entry_loc_valid;
  logic wr_en;
  logic [LOC_W-1:0] wr_loc;
  pss_loc_t wr_data;
  logic [SET_W-1:0] meas_v;
  logic [SET_W-1:0] meas_i;
  logic cc_mode;
  pss_set_t setpoint;
  logic output_on;
  pss_stat_t status;
  int error_cnt = 0;
  int tests_run = 0;

  pss_sequencer #(.TICK(TK)) i_pss_sequencer (.clk(clk), .srst(srst), .key(key),
    .entry_loc(entry_loc), .entry_loc_valid(entry_loc_valid), .wr_en(wr_en),
    .wr_loc(wr_loc), .wr_data(wr_data), .meas_v(meas_v), .meas_i(meas_i),
    .cc_mode(cc_mode), .setpoint(setpoint), .output_on(output_on), .status(status));
  pss_panel_model i_pss_panel_model (.clk(clk), .key(key), .entry_loc(entry_loc),
    .entry_loc_valid(entry_loc_valid), .meas_v(meas_v), .meas_i(meas_i), .cc_mode(cc_mode));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare tasks, one per kind of result
  task automatic chk_set(input string what, input pss_set_t exp, input pss_set_t got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic pss_set_t mk(input logic [15:0] v);
    return {v, v + 16'h0001, v + 16'h0002, v + 16'h0003};
  endfunction

  // Program write; a bounded wait stands in for a handshake the port lacks
  task automatic wr(input logic [5:0] l, input logic [15:0] v, input logic [15:0] dw,
                    input logic [5:0] nx);
    @(posedge clk);
    #1 wr_en = 1'b1;
    wr_loc = l;
    wr_data = {mk(v), dw, nx};
    @(posedge clk);
    #1 wr_en = 1'b0;
  endtask
  task automatic wait_exec(input logic [5:0] l, input int n);
    for (int i = 0; i < n && status.executed_location !== l; i++) @(posedge clk) #1;
    chk_vec("executed", {10'h000, l}, {10'h000, status.executed_location});
  endtask
  task automatic wait_stop(input int n);
    for (int i = 0; i < n && status.running !== 1'b0; i++) @(posedge clk) #1;
    chk_bit("stopped", 1'b0, status.running);
  endtask

  // Start replaced before confirm, pointers followed, loop, reset key
  task automatic t_loop;
    int n;
    i_pss_panel_model.press(K_RUN);
    i_pss_panel_model.give_loc(6'd5);
    i_pss_panel_model.give_loc(6'd1);
    i_pss_panel_model.press(K_ENT);
    chk_set("run start", mk(16'h0100), setpoint);
    chk_bit("running", 1'b1, status.running);
    wait_exec(6'd2, 20);
    chk_set("second loc", mk(16'h0200), setpoint);
    // Two units on location 2, plus one cycle to load the next
    n = 0;
    while (status.executed_location !== 6'd3 && n < 30) begin
      @(posedge clk) #1;
      n++;
    end
    chk_vec("dwell loc 2", 16'(2 * TK + 1), 16'(n));
    wait_exec(6'd3, 30);
    wait_exec(6'd1, 20);
    wait_exec(6'd2, 20);
    i_pss_panel_model.press(K_RST);
    chk_bit("reset running", 1'b0, status.running);
    chk_set("reset set", '0, setpoint);
    chk_bit("reset output", 1'b0, output_on);
  endtask

  // Toggle halts at once and restores the halted location
  task automatic t_toggle;
    i_pss_panel_model.start(K_RUN, 6'd1);
    wait_exec(6'd3, 60);
    i_pss_panel_model.press(K_TOG);
    chk_bit("toggle off", 1'b0, output_on);
    chk_bit("toggle halt", 1'b0, status.running);
    repeat (20) @(posedge clk);
    #1 chk_vec("halted loc", 16'h0003, {10'h000, status.executed_location});
    i_pss_panel_model.press(K_TOG);
    chk_bit("toggle on", 1'b1, output_on);
    chk_set("restored", mk(16'h0300), setpoint);
  endtask

  // Clear lets the dwell finish and holds that location
  task automatic t_clear;
    i_pss_panel_model.start(K_RUN, 6'd2);
    i_pss_panel_model.press(K_CLR);
    chk_bit("still running", 1'b1, status.running);
    wait_stop(20);
    chk_vec("clear loc", 16'h0002, {10'h000, status.executed_location});
    chk_set("clear hold", mk(16'h0200), setpoint);
    chk_bit("clear output", 1'b1, output_on);
  endtask

  // Out-of-range start refused; last location; zero pointer ends; default dwell
  task automatic t_end;
    i_pss_panel_model.start(K_RUN, 6'd41);
    chk_bit("bad start", 1'b0, status.running);
    i_pss_panel_model.press(K_CLR);
    i_pss_panel_model.start(K_RUN, 6'd40);
    chk_set("loc 40", mk(16'h4000), setpoint);
    wait_stop(12);
    chk_vec("end loc", 16'h0028, {10'h000, status.executed_location});
    chk_set("end hold", mk(16'h4000), setpoint);
    chk_bit("end output", 1'b1, output_on);
    // Unwritten location runs the default single unit
    i_pss_panel_model.start(K_RUN, 6'd10);
    repeat (TK - 1) @(posedge clk);
    #1 chk_bit("default dwell", 1'b1, status.running);
    wait_stop(2);
  endtask

  // Single step: status, advance, toggle, clear, abandon, reset
  task automatic t_step;
    i_pss_panel_model.start(K_STEP, 6'd1);
    chk_bit("step mode", 1'b1, status.step_mode);
    chk_bit("local", 1'b1, status.local_mode);
    chk_vec("exec", 16'h0001, {10'h000, status.executed_location});
    chk_vec("pend", 16'h0002, {10'h000, status.pending_location});
    chk_bit("cv", 1'b1, status.voltage_regulation_flag);
    chk_bit("cc", 1'b0, status.current_regulation_flag);
    chk_vec("meas v", 16'h1234, status.meas_v);
    chk_vec("meas i", 16'h0567, status.meas_i);
    // Regulation flags follow the synchronised mode input
    i_pss_panel_model.set_cc(1'b1);
    repeat (3) @(posedge clk);
    #1 chk_bit("cc on", 1'b1, status.current_regulation_flag);
    chk_bit("cv off", 1'b0, status.voltage_regulation_flag);
    i_pss_panel_model.set_cc(1'b0);
    i_pss_panel_model.press(K_STEP);
    chk_vec("step exec", 16'h0002, {10'h000, status.executed_location});
    chk_vec("step pend", 16'h0003, {10'h000, status.pending_location});
    chk_set("step set", mk(16'h0200), setpoint);
    i_pss_panel_model.press(K_TOG);
    chk_bit("step off", 1'b0, output_on);
    chk_bit("status off", 1'b0, status.output_on);
    chk_bit("step kept", 1'b1, status.step_mode);
    i_pss_panel_model.press(K_TOG);
    chk_bit("step on", 1'b1, output_on);
    i_pss_panel_model.press(K_CLR);
    chk_bit("clear exit", 1'b0, status.step_mode);
    chk_set("clear set", mk(16'h0200), setpoint);
    i_pss_panel_model.press(K_STEP);
    i_pss_panel_model.press(K_CLR);
    chk_bit("abandon", 1'b0, status.step_mode);
    chk_vec("abandon loc", 16'h0002, {10'h000, status.executed_location});
    // A zero pointer refuses the step and stays in step mode
    i_pss_panel_model.start(K_STEP, 6'd40);
    chk_vec("end pend", 16'h0000, {10'h000, status.pending_location});
    i_pss_panel_model.press(K_STEP);
    chk_vec("end step", 16'h0028, {10'h000, status.executed_location});
    chk_bit("end step mode", 1'b1, status.step_mode);
    i_pss_panel_model.press(K_RST);
    chk_bit("reset exit", 1'b0, status.step_mode);
    chk_set("reset set", '0, setpoint);
    chk_bit("reset off", 1'b0, output_on);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(40 * 20000);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    results();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    wr_en = 1'b0;
    wr_loc = 6'h00;
    wr_data = '0;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    chk_set("por set", '0, setpoint);
    chk_bit("por output", 1'b0, output_on);
    wr(6'd1, 16'h0100, 16'h0001, 6'd2);
    wr(6'd2, 16'h0200, 16'h0002, 6'd3);
    wr(6'd3, 16'h0300, 16'h0001, 6'd1);
    wr(6'd40, 16'h4000, 16'h0000, 6'd0);
    t_loop();
    t_toggle();
    t_clear();
    t_end();
    t_step();
    results();
  end
endmodule // tb_top
`default_nettype wire
